// File: logic/output_switch.sv
`timescale 1ns/1ps
`default_nettype none
`include "output_switch_map.svh"
module output_switch #(
  parameter int RAMP_CYC = `OSW_RAMP_CYC
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst_b,
  input  wire logic [1:0]                   i_output_config_select,
  input  wire logic [1:0]                   i_input_function_select,
  input  wire logic                         i_hand_priority_select,
  input  wire logic                         i_fault_to_hand_select,
  input  wire logic [1:0]                   i_hand_auto_lock_select,
  input  wire logic                         i_position_display_source,
  input  wire logic                         i_display_invert_select,
  input  wire logic [2:0]                   i_digital_out_source,
  input  wire logic                         i_digital_out_invert,
  input  wire logic                         i_alarm_module_enable,
  input  wire logic                         i_transmitter_watch_select,
  input  wire output_switch_pkg::value_t    i_auto_output_value,
  input  wire output_switch_pkg::value_t    i_safety_output_value,
  input  wire output_switch_pkg::value_t    i_follow_output_value,
  input  wire output_switch_pkg::value_t    i_serial_follow_value,
  input  wire output_switch_pkg::value_t    i_actuator_position_feedback,
  input  wire logic                         i_digital_input,
  input  wire logic                         i_serial_port_safety,
  input  wire logic                         i_serial_port_freeze,
  input  wire logic                         i_serial_port_follow,
  input  wire logic                         i_serial_port_dout,
  input  wire logic                         i_computer_mode,
  input  wire logic                         i_computer_ready,
  input  wire logic                         i_transmitter_fault,
  input  wire logic                         i_hand_key,
  input  wire logic                         i_key_up,
  input  wire logic                         i_key_down,
  input  wire logic                         i_step_plus_req,
  input  wire logic                         i_step_minus_req,
  input  wire logic [1:0]                   i_alarm_req,
  input  wire logic                         i_param_lock_input,
  input  wire logic                         i_param_prompt_req,
  output output_switch_pkg::mode_t          o_mode,
  output output_switch_pkg::value_t         o_output_value,
  output logic                              o_output_hold,
  output logic                              o_step_plus,
  output logic                              o_step_minus,
  output logic [1:0]                        o_relay,
  output logic [3:0]                        o_module_out,
  output logic                              o_disp_is_h,
  output logic [7:0]                        o_disp_value,
  output logic                              o_disp_neg,
  output logic [1:0]                        o_disp_point,
  output logic                              o_hand_led,
  output logic                              o_digital_out,
  output logic                              o_param_prompt
);
  output_switch_pkg::mode_t   mode_q, mode_d;
  output_switch_pkg::value_t  out_q, out_d;
  logic                       hand_sel_q, hand_sel_d;
  logic                       adj_block_q, adj_block_d;
  logic                       key_dly_q;
  logic                       plus_q, plus_d, minus_q, minus_d;
  logic                       dout_q, dout_d;
  logic                       prompt_q, prompt_d;
  logic                       disp_h_q, disp_h_d, disp_neg_q, disp_neg_d;
  logic [7:0]                 disp_q, disp_d;
  output_switch_pkg::value_t  hand_value;
  logic                       key_edge, step_out, step_sim;
  logic                       req_safety, req_freeze, req_follow, req_hand, serial_follow;
  logic                       xmtr_to_hand;
  output_switch_pkg::value_t  disp_src;
  logic signed [12:0]         disp_pct;

  function automatic logic din_is(input logic [1:0] sel, input logic [1:0] fn);
    din_is = (sel == fn);
  endfunction : din_is

  assign step_out     = i_output_config_select[1];
  assign step_sim     = (i_output_config_select == `OSW_CFG_STEP_INT);
  assign key_edge     = i_hand_key && !key_dly_q;
  assign xmtr_to_hand = i_transmitter_watch_select && i_fault_to_hand_select && i_transmitter_fault;

  always_comb begin
    req_safety    = i_serial_port_safety || (i_digital_input && din_is(i_input_function_select, `OSW_DIN_SAFETY));
    req_freeze    = i_serial_port_freeze || (i_digital_input && din_is(i_input_function_select, `OSW_DIN_FREEZE));
    serial_follow = i_serial_port_follow && !i_serial_port_freeze && !i_serial_port_safety;
    req_follow    = !step_sim && (serial_follow || (!step_out && i_digital_input
                    && din_is(i_input_function_select, `OSW_DIN_FOLLOW)));
    req_hand      = hand_sel_q || xmtr_to_hand || (i_digital_input && din_is(i_input_function_select, `OSW_DIN_HAND));
  end

  // hand selection and lock
  always_comb begin
    hand_sel_d  = hand_sel_q;
    adj_block_d = adj_block_q;
    unique case (i_hand_auto_lock_select)
      `OSW_LOCK_AUTO: begin
        hand_sel_d  = 1'b0;
        adj_block_d = 1'b0;
      end
      `OSW_LOCK_HAND: begin
        hand_sel_d = 1'b1;
        if (key_edge) begin
          adj_block_d = !adj_block_q;
        end
      end
      default: begin
        adj_block_d = 1'b0;
        if (key_edge) begin
          hand_sel_d = !hand_sel_q;
        end
        if (xmtr_to_hand) begin
          hand_sel_d = 1'b1;
        end
      end
    endcase
  end

  // mode priority, one decision per clock cycle
  always_comb begin
    if (req_safety) begin
      mode_d = output_switch_pkg::MODE_SAFETY;
    end else if (req_hand && (i_hand_priority_select || (!req_freeze && !req_follow))) begin
      mode_d = output_switch_pkg::MODE_HAND;
    end else if (req_freeze) begin
      mode_d = output_switch_pkg::MODE_FREEZE;
    end else if (req_follow) begin
      mode_d = output_switch_pkg::MODE_FOLLOW;
    end else begin
      mode_d = output_switch_pkg::MODE_AUTO;
    end
  end

  // effective output value and step commands
  always_comb begin
    out_d   = out_q;
    plus_d  = 1'b0;
    minus_d = 1'b0;
    unique case (mode_d)
      output_switch_pkg::MODE_SAFETY: begin
        out_d = i_safety_output_value;
        if (step_sim) begin
          minus_d = (i_safety_output_value < `OSW_HALF_SCALE);
          plus_d  = (i_safety_output_value > `OSW_HALF_SCALE);
        end else begin
          plus_d  = step_out && i_step_plus_req;
          minus_d = step_out && i_step_minus_req;
        end
      end
      output_switch_pkg::MODE_FREEZE: begin
        out_d = out_q;
      end
      output_switch_pkg::MODE_FOLLOW: begin
        out_d   = serial_follow ? i_serial_follow_value : i_follow_output_value;
        plus_d  = step_out && i_step_plus_req;
        minus_d = step_out && i_step_minus_req;
      end
      output_switch_pkg::MODE_HAND: begin
        out_d = hand_value;
        if (step_out) begin
          plus_d  = (hand_value > `OSW_FULL_SCALE) || i_step_plus_req;
          minus_d = (hand_value < 12'sh000) || i_step_minus_req;
        end
      end
      output_switch_pkg::MODE_AUTO: begin
        out_d   = i_auto_output_value;
        plus_d  = step_out && i_step_plus_req;
        minus_d = step_out && i_step_minus_req;
      end
    endcase
  end

  // display, status output, prompt
  always_comb begin
    disp_src   = i_position_display_source ? i_actuator_position_feedback : out_d;
    disp_pct   = 13'(disp_src) / 13'sd10;
    if (i_display_invert_select) begin
      disp_pct = 13'sd100 - disp_pct;
    end
    if (disp_pct < -13'sd9) begin
      disp_pct = -13'sd9;
    end else if (disp_pct > 13'sd109) begin
      disp_pct = 13'sd109;
    end
    disp_h_d   = (disp_pct > 13'sd100);
    disp_neg_d = (disp_pct < 13'sd0);
    disp_d     = disp_h_d ? 8'(disp_pct - 13'sd100) : (disp_neg_d ? 8'(-disp_pct) : 8'(disp_pct));
    unique case (i_digital_out_source)
      `OSW_DO_NOT_COMP:  dout_d = !i_computer_mode;
      `OSW_DO_HAND:      dout_d = req_hand;
      `OSW_DO_NOT_READY: dout_d = !i_computer_ready || req_hand;
      `OSW_DO_XMTR:      dout_d = i_transmitter_watch_select && i_transmitter_fault;
      `OSW_DO_SERIAL:    dout_d = i_serial_port_dout;
      default:           dout_d = 1'b0;
    endcase
    dout_d   = dout_d ^ i_digital_out_invert;
    prompt_d = i_param_prompt_req && !i_param_lock_input;
  end

  hand_ramp #(
    .RAMP_CYC (RAMP_CYC)
  ) u_hand_ramp (
    .i_mclk       (i_mclk),
    .i_rst_b      (i_rst_b),
    .i_enable     (mode_q == output_switch_pkg::MODE_HAND && !adj_block_q),
    .i_step_out   (step_out),
    .i_key_up     (i_key_up),
    .i_key_down   (i_key_down),
    .i_load_value (out_q),
    .i_load       (mode_q != output_switch_pkg::MODE_HAND && !step_out),
    .o_value      (hand_value)
  );

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_q      <= output_switch_pkg::MODE_AUTO;
      out_q       <= '0;
      hand_sel_q  <= 1'b0;
      adj_block_q <= 1'b0;
      key_dly_q   <= 1'b0;
      plus_q      <= 1'b0;
      minus_q     <= 1'b0;
      dout_q      <= 1'b0;
      prompt_q    <= 1'b0;
      disp_h_q    <= 1'b0;
      disp_neg_q  <= 1'b0;
      disp_q      <= '0;
    end else begin
      mode_q      <= mode_d;
      out_q       <= out_d;
      hand_sel_q  <= hand_sel_d;
      adj_block_q <= adj_block_d;
      key_dly_q   <= i_hand_key;
      plus_q      <= plus_d;
      minus_q     <= minus_d;
      dout_q      <= dout_d;
      prompt_q    <= prompt_d;
      disp_h_q    <= disp_h_d;
      disp_neg_q  <= disp_neg_d;
      disp_q      <= disp_d;
    end
  end

  assign o_mode         = mode_q;
  assign o_output_value = out_q;
  assign o_output_hold  = (mode_q == output_switch_pkg::MODE_FREEZE);
  // step commands go to the relays or to the alarm module, never both, and always to o_step_plus/o_step_minus and the display points
  assign o_step_plus    = plus_q;
  assign o_step_minus   = minus_q;
  assign o_relay        = i_alarm_module_enable ? 2'h0 : {plus_q, minus_q};
  assign o_module_out   = i_alarm_module_enable ? {i_alarm_req, plus_q, minus_q} : 4'h0;
  assign o_disp_is_h    = disp_h_q;
  assign o_disp_value   = disp_q;
  assign o_disp_neg     = disp_neg_q;
  assign o_disp_point   = {plus_q, minus_q};
  assign o_hand_led     = (mode_q == output_switch_pkg::MODE_HAND) && !adj_block_q;
  assign o_digital_out  = dout_q;
  assign o_param_prompt = prompt_q;

  property p_safety_wins;
    @(posedge i_mclk) disable iff (!i_rst_b)
    req_safety |=> (o_mode == output_switch_pkg::MODE_SAFETY && o_output_value == $past(i_safety_output_value));
  endproperty
  a_safety_wins: assert property (p_safety_wins) else $error("safety not taken");
  property p_freeze_holds;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (mode_d == output_switch_pkg::MODE_FREEZE && mode_q == output_switch_pkg::MODE_FREEZE) |=> $stable(o_output_value);
  endproperty
  a_freeze_holds: assert property (p_freeze_holds) else $error("frozen output moved");
  property p_prio0;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!req_safety && !i_hand_priority_select && req_freeze) |=> (o_mode == output_switch_pkg::MODE_FREEZE);
  endproperty
  a_prio0: assert property (p_prio0) else $error("freeze did not interrupt hand");
  property p_prio1;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!req_safety && i_hand_priority_select && req_hand) |=> (o_mode == output_switch_pkg::MODE_HAND);
  endproperty
  a_prio1: assert property (p_prio1) else $error("hand not entered");
  property p_sim_safety;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (req_safety && step_sim && i_safety_output_value < `OSW_HALF_SCALE) |=> (o_step_minus && !o_step_plus);
  endproperty
  a_sim_safety: assert property (p_sim_safety) else $error("safety step direction wrong");
  property p_no_follow_sim;
    @(posedge i_mclk) disable iff (!i_rst_b)
    step_sim |=> (o_mode != output_switch_pkg::MODE_FOLLOW);
  endproperty
  a_no_follow_sim: assert property (p_no_follow_sim) else $error("follow with step sim");
  property p_relay_off;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_alarm_module_enable |-> (o_relay == 2'h0 && o_module_out[1:0] == o_disp_point);
  endproperty
  a_relay_off: assert property (p_relay_off) else $error("relays active with module");
  property p_lock_prompt;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_param_lock_input |=> !o_param_prompt;
  endproperty
  a_lock_prompt: assert property (p_lock_prompt) else $error("prompt shown while locked");
  property p_auto_only;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_hand_auto_lock_select == `OSW_LOCK_AUTO) ##1 (i_hand_auto_lock_select == `OSW_LOCK_AUTO)
      |-> !hand_sel_q;
  endproperty
  a_auto_only: assert property (p_auto_only) else $error("hand selected in auto-only");
  property p_dout_inv;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (i_digital_out_source == `OSW_DO_SERIAL)
      |=> (o_digital_out == ($past(i_serial_port_dout) ^ $past(i_digital_out_invert)));
  endproperty
  a_dout_inv: assert property (p_dout_inv) else $error("status output wrong");
endmodule : output_switch
`default_nettype wire

// File: logic/output_switch_map.svh
`ifndef OUTPUT_SWITCH_MAP_SVH
`define OUTPUT_SWITCH_MAP_SVH
// values in units of 0.1 %, signed 12 bit
`define OSW_VAL_W          12
`define OSW_FULL_SCALE     12'sh3e8
`define OSW_HALF_SCALE     12'sh1f4
`define OSW_STEP_MIN       12'sh001
`define OSW_CMD_MINUS      12'shf9c
`define OSW_CMD_PLUS       12'sh44c
`define OSW_DISP_MIN       12'shfa6
`define OSW_DISP_MAX       12'sh442
// ramp timing
`define OSW_CLK_NS         50
`define OSW_RAMP_MS        100
`define OSW_RAMP_CYC       ((`OSW_RAMP_MS * 1000000) / `OSW_CLK_NS)
`define OSW_SWEEP_S        5
`define OSW_SWEEP_TICKS    ((`OSW_SWEEP_S * 1000) / `OSW_RAMP_MS)
// step growth per tick so that 45 ticks roughly cover 100 %: 1+2+..+44 ~ 990
`define OSW_STEP_GROW      12'sh001
// setting encodings
`define OSW_CFG_CONT       2'h0
`define OSW_CFG_TWOPOS     2'h1
`define OSW_CFG_STEP_INT   2'h2
`define OSW_CFG_STEP_EXT   2'h3
`define OSW_LOCK_FREE      2'h0
`define OSW_LOCK_AUTO      2'h1
`define OSW_LOCK_HAND      2'h2
`define OSW_DIN_SAFETY     2'h0
`define OSW_DIN_FREEZE     2'h1
`define OSW_DIN_FOLLOW     2'h2
`define OSW_DIN_HAND       2'h3
`define OSW_DO_NOT_COMP    3'h0
`define OSW_DO_HAND        3'h1
`define OSW_DO_NOT_READY   3'h2
`define OSW_DO_XMTR        3'h3
`define OSW_DO_SERIAL      3'h4
`endif

// File: logic/output_switch_pkg.sv
package output_switch_pkg;
  typedef enum logic [2:0] {
    MODE_AUTO,
    MODE_FOLLOW,
    MODE_FREEZE,
    MODE_HAND,
    MODE_SAFETY
  } mode_t;
  typedef logic signed [11:0] value_t;
endpackage : output_switch_pkg

// File: logic/hand_ramp.sv
`timescale 1ns/1ps
`default_nettype none
`include "output_switch_map.svh"
module hand_ramp #(
  parameter int RAMP_CYC = `OSW_RAMP_CYC
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_rst_b,
  input  wire logic                         i_enable,
  input  wire logic                         i_step_out,
  input  wire logic                         i_key_up,
  input  wire logic                         i_key_down,
  input  wire output_switch_pkg::value_t    i_load_value,
  input  wire logic                         i_load,
  output output_switch_pkg::value_t         o_value
);
  localparam int CW = $clog2(RAMP_CYC + 1);
  logic [CW-1:0]              tick_cnt_q, tick_cnt_d;
  output_switch_pkg::value_t  step_q, step_d;
  output_switch_pkg::value_t  value_q, value_d;
  logic                       held;
  logic                       tick;
  logic signed [12:0]         sum;

  assign held = i_enable && (i_key_up ^ i_key_down);
  assign tick = (tick_cnt_q == CW'(RAMP_CYC - 1));

  always_comb begin
    tick_cnt_d = held ? (tick ? '0 : tick_cnt_q + CW'(1)) : '0;
    step_d     = step_q;
    value_d    = value_q;
    sum        = '0;
    if (i_load) begin
      value_d = i_load_value;
    end else if (!held) begin
      step_d = `OSW_STEP_MIN;
      if (i_step_out) begin
        value_d = `OSW_HALF_SCALE;
      end
    end else if (i_step_out) begin
      value_d = i_key_up ? `OSW_CMD_PLUS : `OSW_CMD_MINUS;
    end else if (tick) begin
      // linear growth: ~45 ticks (about 5 s) cover the full range
      step_d = step_q + `OSW_STEP_GROW;
      sum    = i_key_up ? 13'(value_q) + 13'(step_q) : 13'(value_q) - 13'(step_q);
      if (sum > 13'(`OSW_FULL_SCALE)) begin
        value_d = `OSW_FULL_SCALE;
      end else if (sum < 13'sh0) begin
        value_d = '0;
      end else begin
        value_d = sum[11:0];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt_q <= '0;
      step_q     <= `OSW_STEP_MIN;
      value_q    <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      step_q     <= step_d;
      value_q    <= value_d;
    end
  end

  assign o_value = value_q;

  property p_step_restart;
    @(posedge i_mclk) disable iff (!i_rst_b)
    (!held && !i_load) |=> (step_q == `OSW_STEP_MIN);
  endproperty
  a_step_restart: assert property (p_step_restart) else $error("ramp step not reset");
endmodule : hand_ramp
`default_nettype wire

// File: test/actuator_model.sv
`timescale 1ns/1ps
`default_nettype none
module actuator_model (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_plus,
  input  wire logic                 i_minus,
  output output_switch_pkg::value_t o_pos
);
  // one count per clock is far faster than a motor, but only the direction matters here
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) o_pos <= 12'sh190;
    else if (i_plus && o_pos < 12'sh3e8) o_pos <= o_pos + 12'sh001;
    else if (i_minus && o_pos > 12'sh000) o_pos <= o_pos - 12'sh001;
  end
endmodule : actuator_model
`default_nettype wire

// File: test/output_switch_test.sv
`timescale 1ns/1ps
`default_nettype none
module output_switch_test;
  localparam int RC = 4;
  logic i_mclk = 0, i_rst_b = 0;
  logic [1:0] cfg = 0, dsel = 0, lock = 0, alarm = 0, rly, dpt;
  logic [2:0] dos = 0;
  logic hp = 0, f2h = 0, dsrc = 0, dinv = 0, doinv = 0, amod = 0, tw = 0, din = 0, ss = 0, sf = 0, sfo = 0;
  logic sdo = 0, cm = 0, cr = 0, tf = 0, hk = 0, ku = 0, kd = 0, lk = 0, pr = 0;
  logic hold, sp, sm, dh, dneg, led, dout, prompt;
  logic [3:0] mout;
  logic [7:0] dval;
  output_switch_pkg::value_t av = 0, sv = 0, fv = 0, sfv = 0, pos, val, last;
  output_switch_pkg::mode_t mode;
  int failures = 0, cmp_count = 0, i, seed;
  always #25 i_mclk = ~i_mclk;
  actuator_model actuator_model_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_plus(sp), .i_minus(sm), .o_pos(pos));
  output_switch #(.RAMP_CYC(RC)) output_switch_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_output_config_select(cfg), .i_input_function_select(dsel), .i_hand_priority_select(hp),
    .i_fault_to_hand_select(f2h), .i_hand_auto_lock_select(lock), .i_position_display_source(dsrc),
    .i_display_invert_select(dinv), .i_digital_out_source(dos), .i_digital_out_invert(doinv),
    .i_alarm_module_enable(amod), .i_transmitter_watch_select(tw), .i_auto_output_value(av),
    .i_safety_output_value(sv), .i_follow_output_value(fv), .i_serial_follow_value(sfv),
    .i_actuator_position_feedback(pos), .i_digital_input(din), .i_serial_port_safety(ss),
    .i_serial_port_freeze(sf), .i_serial_port_follow(sfo), .i_serial_port_dout(sdo), .i_computer_mode(cm),
    .i_computer_ready(cr), .i_transmitter_fault(tf), .i_hand_key(hk), .i_key_up(ku), .i_key_down(kd),
    .i_step_plus_req(1'b0), .i_step_minus_req(1'b0), .i_alarm_req(alarm), .i_param_lock_input(lk),
    .i_param_prompt_req(pr), .o_mode(mode), .o_output_value(val), .o_output_hold(hold), .o_step_plus(sp),
    .o_step_minus(sm), .o_relay(rly), .o_module_out(mout), .o_disp_is_h(dh), .o_disp_value(dval),
    .o_disp_neg(dneg), .o_disp_point(dpt), .o_hand_led(led), .o_digital_out(dout), .o_param_prompt(prompt));
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : step
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic rst;
    i_rst_b = 0;
    step(1);
    i_rst_b = 1;
    step(1);
  endtask : rst
  task automatic press;
    hk = 1;
    step(1);
    hk = 0;
    step(4);
  endtask : press
  // expected display word {is_h, neg, digits}; truncating division keeps 1 % steps
  function automatic logic [9:0] disp(input int v, input logic inv);
    int p;
    p = v / 10;
    if (inv) p = 100 - p;
    if (p > 109) p = 109;
    if (p < -9) p = -9;
    if (p > 100) return {2'b10, 8'(p % 10)};
    return {1'b0, p < 0, 8'(p < 0 ? -p : p)};
  endfunction : disp
  task automatic ramp(input logic up);
    int d, c;
    output_switch_pkg::value_t p;
    d = 1; c = 0; ku = up; kd = !up; p = val;
    repeat (8 * RC) begin
      step(1);
      c++;
      if (val !== p) begin
        check(up ? val - p : p - val, 12'(d), "ramp step");
        if (d > 1) check(12'(c), 12'(RC), "ramp period");
        d++; c = 0; p = val;
      end
    end
    ku = 0; kd = 0;
    step(2);
    p = val;
    step(3 * RC);
    check(val, p, "hand value held");
    check(12'(d > 3), 12'h001, "ramp ran");
  endtask : ramp
  initial begin
    #(50 * 8000);
    failures++;
    complete_run();
  end
  initial begin
    seed = 32'h45975f09;
    step(4);
    rst();
    for (i = 0; i < 20; i++) begin
      av = 12'($unsigned($random(seed)) % 1001); dinv = $random(seed);
      step(4);
      check(val, av, "auto value");
      check(mode, output_switch_pkg::MODE_AUTO, "auto mode");
      check({dh, dneg, dval}, disp(int'(av), dinv), "display");
    end
    $display("auto and display test done");
    for (i = 0; i < 8; i++) begin
      {ss, sf, sfo} = 3'h0; step(4); last = val;
      {ss, sf, sfo} = 3'(i); av = 12'($unsigned($random(seed)) % 1001);
      sv = 12'($unsigned($random(seed)) % 1001); sfv = 12'($unsigned($random(seed)) % 1001);
      step(4);
      check(mode, ss ? output_switch_pkg::MODE_SAFETY : sf ? output_switch_pkg::MODE_FREEZE :
        sfo ? output_switch_pkg::MODE_FOLLOW : output_switch_pkg::MODE_AUTO, "serial priority");
      check(val, ss ? sv : sf ? last : sfo ? sfv : av, "serial value");
      check(12'(hold), 12'(!ss && sf), "hold flag");
    end
    ss = 1; sf = 0; sfo = 0; sv = 12'sh41a; dinv = 0;
    step(5);
    check({dh, dneg, dval}, 10'h205, "display h digit");
    ss = 0;
    for (i = 0; i < 4; i++) begin
      din = 0; dsel = 2'(i); fv = 12'($unsigned($random(seed)) % 1001); step(4);
      din = 1; step(4);
      check(mode, i == 0 ? output_switch_pkg::MODE_SAFETY : i == 1 ? output_switch_pkg::MODE_FREEZE :
        i == 2 ? output_switch_pkg::MODE_FOLLOW : output_switch_pkg::MODE_HAND, "digital input");
      if (i == 2) check(val, fv, "follow value");
    end
    din = 0; rst();
    $display("request priority test done");
    cfg = 2; ss = 1; alarm = 2'h2;
    for (i = 0; i < 4; i++) begin
      sv = i[0] ? 12'sh2bc : 12'sh12c; amod = i[1]; step(4);
      check({sp, sm}, i[0] ? 2'h2 : 2'h1, "safety step");
      check(dpt, {sp, sm}, "points");
      check({rly, mout}, amod ? {2'h0, alarm, sp, sm} : {sp, sm, 4'h0}, "module routing");
    end
    ss = 0; sfo = 1; step(4);
    check(mode, output_switch_pkg::MODE_AUTO, "no follow with simulation");
    cfg = 3; step(4);
    check(mode, output_switch_pkg::MODE_FOLLOW, "serial follow with feedback");
    sfo = 0; sf = 1; step(4);
    check({sp, sm}, 2'h0, "freeze no steps");
    sf = 0; press(); ku = 1; step(3);
    check({sp, sm}, 2'h2, "hand key drives plus");
    ku = 0; kd = 1; step(3);
    check({sp, sm}, 2'h1, "hand key drives minus");
    kd = 0; cfg = 0; amod = 0; av = 12'sh064; rst();
    $display("step output test done");
    step(4);
    press();
    check(mode, output_switch_pkg::MODE_HAND, "hand mode");
    check(12'(led), 12'h001, "hand led");
    ramp(1);
    ramp(0);
    ku = 1; step(30 * RC);
    check(12'(val < 12'sh3e8), 12'h001, "sweep not instant");
    step(20 * RC + 2);
    check(val, 12'sh3e8, "full sweep");
    ku = 0;
    dos = 1; doinv = 0; sf = 1; step(4);
    check(mode, output_switch_pkg::MODE_FREEZE, "freeze over hand");
    check(12'(dout), 12'h001, "prepared hand out");
    hp = 1; step(4);
    check(mode, output_switch_pkg::MODE_HAND, "hand over freeze");
    ss = 1; step(4);
    check(mode, output_switch_pkg::MODE_SAFETY, "safety over hand");
    ss = 0; sf = 0; hp = 0; rst();
    $display("hand test done");
    lock = 1; press();
    check(mode, output_switch_pkg::MODE_AUTO, "auto only");
    lock = 2; step(4);
    check(mode, output_switch_pkg::MODE_HAND, "hand only");
    press();
    check(12'(led), 12'h000, "led off");
    lock = 0; rst();
    for (i = 0; i < 8; i++) begin
      dos = 3'(i % 5); cm = $random(seed); cr = $random(seed); sdo = $random(seed); doinv = $random(seed);
      lk = $random(seed); pr = 1; step(4);
      check(12'(dout), 12'(doinv ^ (dos == 0 ? !cm : dos == 2 ? !cr : dos == 4 ? sdo : 1'b0)), "status out");
      check(12'(prompt), 12'(!lk), "prompt lock");
    end
    dsrc = 1; dinv = 1; step(4);
    check({dh, dneg, dval}, disp(int'(pos), 1'b1), "feedback display");
    dos = 3; doinv = 1; tw = 1; f2h = 1; tf = 1; step(4);
    check(12'(dout), 12'h000, "fault status out");
    check(mode, output_switch_pkg::MODE_HAND, "fault to hand");
    $display("status and lock test done");
    complete_run();
  end
endmodule : output_switch_test
`default_nettype wire
